// File: rtl/cbx_pkg.sv
// Constants and state types for the compare-branch and clear-accumulator unit
// Assumes an 8-bit core with a 16-bit program counter
`default_nettype none

package cbx_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned PC_W   = 16;
  localparam int unsigned ADDR_W = 8;

  // Opcodes handled by this unit
  localparam logic [7:0] OP_CMP_A_IMM  = 8'hb4;
  localparam logic [7:0] OP_CMP_A_DIR  = 8'hb5;
  localparam logic [6:0] OP_CMP_IND_HI = 7'h5b;
  localparam logic [4:0] OP_CMP_REG_HI = 5'h17;
  localparam logic [7:0] OP_CLEAR_ACC  = 8'he4;

  // Instruction lengths in bytes
  localparam logic [15:0] CMP_LEN   = 16'h0003;
  localparam logic [15:0] CLEAR_LEN = 16'h0001;

  // Value forced into the accumulator by the clear operation
  localparam logic [7:0] ACC_CLEARED = 8'h00;

  // Reset values
  localparam logic [15:0] PC_RST   = 16'h0000;
  localparam logic [7:0]  BYTE_RST = 8'h00;

  typedef enum logic [1:0] {
    CBX_IDLE,
    CBX_PTR,
    CBX_OPER
  } cbx_state_t;

  typedef struct packed {
    cbx_state_t  st;
    logic [7:0]  op;
    logic [7:0]  imm;
    logic [7:0]  rel;
    logic [15:0] pc_base;
    logic [7:0]  acc;
    logic [7:0]  rd_addr;
    logic        rd_en;
    logic [15:0] pc_out;
    logic        pc_we;
    logic [7:0]  acc_out;
    logic        acc_we;
    logic        carry_out;
    logic        carry_we;
    logic        done;
  } cbx_regs_t;

endpackage : cbx_pkg

`default_nettype wire

// File: rtl/cbx_exec.sv
// Execution unit for compare-and-branch-if-not-equal and clear accumulator
// Assumes opcode bytes arrive with start, and RAM reads are combinational
//
// Contract
// - Direct compare: pc plus three, branch if differ
// - Direct compare carry when A below; operands untouched
// - Immediate compare: pc plus three, branch, carry
// - Register form: low bits select, three bytes
// - Clear zeroes accumulator, flags kept, one cycle
// - Comparisons are unsigned
// - Target adds signed offset to advanced pc
`timescale 1ns/1ns
`default_nettype none

module cbx_exec (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  byte2,
  input  wire logic [7:0]  byte3,
  input  wire logic [15:0] pc_in,
  input  wire logic [7:0]  acc_in,
  input  wire logic [1:0]  bank_sel,
  output logic             busy,
  output logic             ram_rd_en,
  output logic [7:0]       ram_rd_addr,
  input  wire logic [7:0]  ram_rd_data,
  output logic             done,
  output logic [15:0]      pc_out,
  output logic             pc_we,
  output logic [7:0]       acc_out,
  output logic             acc_we,
  output logic             carry_out,
  output logic             carry_we
);

  cbx_pkg::cbx_regs_t q;
  cbx_pkg::cbx_regs_t d;
  logic [7:0]         oper_dest;
  logic [7:0]         oper_src;
  logic               acc_form;

  // Address of a working register in the selected bank
  function automatic logic [7:0] reg_addr(input logic [1:0] bank,
                                          input logic [2:0] sel);
    reg_addr = {3'h0, bank, sel};
  endfunction : reg_addr

  // Advanced pc plus sign-extended displacement
  function automatic logic [15:0] rel_target(input logic [15:0] base,
                                             input logic [7:0]  rel);
    rel_target = base + {{8{rel[7]}}, rel};
  endfunction : rel_target

  assign acc_form  = (q.op == cbx_pkg::OP_CMP_A_DIR) ||
                     (q.op == cbx_pkg::OP_CMP_A_IMM);
  assign oper_dest = acc_form ? q.acc : ram_rd_data;
  assign oper_src  = (q.op == cbx_pkg::OP_CMP_A_DIR) ? ram_rd_data : q.imm;

  always_comb begin
    d          = q;
    d.done     = 1'h0;
    d.pc_we    = 1'h0;
    d.acc_we   = 1'h0;
    d.carry_we = 1'h0;
    case (q.st)
      cbx_pkg::CBX_IDLE: begin
        d.rd_en = 1'h0;
        if (start) begin
          d.op      = opcode;
          d.imm     = byte2;
          d.rel     = byte3;
          d.acc     = acc_in;
          d.pc_base = pc_in + cbx_pkg::CMP_LEN;
          if (opcode == cbx_pkg::OP_CLEAR_ACC) begin
            d.acc_out = cbx_pkg::ACC_CLEARED;
            d.acc_we  = 1'h1;
            d.pc_out  = pc_in + cbx_pkg::CLEAR_LEN;
            d.pc_we   = 1'h1;
            d.done    = 1'h1;
          end else if (opcode == cbx_pkg::OP_CMP_A_DIR) begin
            d.rd_addr = byte2;
            d.rd_en   = 1'h1;
            d.st      = cbx_pkg::CBX_OPER;
          end else if (opcode == cbx_pkg::OP_CMP_A_IMM) begin
            d.st = cbx_pkg::CBX_OPER;
          end else if (opcode[7:3] == cbx_pkg::OP_CMP_REG_HI) begin
            d.rd_addr = reg_addr(bank_sel, opcode[2:0]);
            d.rd_en   = 1'h1;
            d.st      = cbx_pkg::CBX_OPER;
          end else if (opcode[7:1] == cbx_pkg::OP_CMP_IND_HI) begin
            d.rd_addr = reg_addr(bank_sel, {2'h0, opcode[0]});
            d.rd_en   = 1'h1;
            d.st      = cbx_pkg::CBX_PTR;
          end
        end
      end
      cbx_pkg::CBX_PTR: begin
        d.rd_addr = ram_rd_data;
        d.st      = cbx_pkg::CBX_OPER;
      end
      cbx_pkg::CBX_OPER: begin
        d.rd_en     = 1'h0;
        d.carry_out = oper_dest < oper_src;
        d.carry_we  = 1'h1;
        d.pc_we     = 1'h1;
        d.done      = 1'h1;
        d.st        = cbx_pkg::CBX_IDLE;
        if (oper_dest != oper_src) begin
          d.pc_out = rel_target(q.pc_base, q.rel);
        end else begin
          d.pc_out = q.pc_base;
        end
      end
      default: begin
        d.st = cbx_pkg::CBX_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q           <= '0;
      q.st        <= cbx_pkg::CBX_IDLE;
      q.pc_base   <= cbx_pkg::PC_RST;
      q.pc_out    <= cbx_pkg::PC_RST;
      q.acc_out   <= cbx_pkg::BYTE_RST;
      q.rd_addr   <= cbx_pkg::BYTE_RST;
    end else begin
      q <= d;
    end
  end

  assign busy        = (q.st != cbx_pkg::CBX_IDLE);
  assign ram_rd_en   = q.rd_en;
  assign ram_rd_addr = q.rd_addr;
  assign done        = q.done;
  assign pc_out      = q.pc_out;
  assign pc_we       = q.pc_we;
  assign acc_out     = q.acc_out;
  assign acc_we      = q.acc_we;
  assign carry_out   = q.carry_out;
  assign carry_we    = q.carry_we;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic take;
  assign take = start && !busy;

  property p_dir_pc;
    take && opcode == cbx_pkg::OP_CMP_A_DIR |-> ##2 done && pc_we &&
      pc_out == (($past(acc_in, 2) != $past(ram_rd_data))
        ? rel_target($past(pc_in, 2) + 16'h0003, $past(byte3, 2))
        : $past(pc_in, 2) + 16'h0003);
  endproperty
  a_dir_pc: assert property (p_dir_pc) else $error("direct pc wrong");

  property p_dir_carry;
    take && opcode == cbx_pkg::OP_CMP_A_DIR |=> ram_rd_addr == $past(byte2)
      ##1 carry_we && !acc_we &&
      carry_out == ($past(acc_in, 2) < $past(ram_rd_data));
  endproperty
  a_dir_carry: assert property (p_dir_carry) else $error("direct carry");

  property p_imm;
    take && opcode == cbx_pkg::OP_CMP_A_IMM |-> ##2 done && !acc_we &&
      carry_out == ($past(acc_in, 2) < $past(byte2, 2)) &&
      pc_out == (($past(acc_in, 2) != $past(byte2, 2))
        ? rel_target($past(pc_in, 2) + 16'h0003, $past(byte3, 2))
        : $past(pc_in, 2) + 16'h0003);
  endproperty
  a_imm: assert property (p_imm) else $error("immediate compare wrong");

  property p_reg;
    take && opcode[7:3] == 5'h17 |=> ram_rd_en &&
      ram_rd_addr == {3'h0, $past(bank_sel), $past(opcode[2:0])} && !done
      ##1 done && carry_we &&
      carry_out == ($past(ram_rd_data) < $past(byte2, 2));
  endproperty
  a_reg: assert property (p_reg) else $error("register compare wrong");

  // Register form branches like the accumulator forms
  property p_reg_pc;
    take && opcode[7:3] == 5'h17 |-> ##2 pc_we && !acc_we &&
      pc_out == (($past(ram_rd_data) != $past(byte2, 2))
        ? rel_target($past(pc_in, 2) + cbx_pkg::CMP_LEN, $past(byte3, 2))
        : $past(pc_in, 2) + cbx_pkg::CMP_LEN);
  endproperty
  a_reg_pc: assert property (p_reg_pc) else $error("register pc wrong");

  property p_ind;
    take && opcode[7:1] == 7'h5b |=>
      ram_rd_addr == {3'h0, $past(bank_sel), 2'h0, $past(opcode[0])}
      ##1 ram_rd_addr == $past(ram_rd_data) && !done
      ##1 done && carry_out == ($past(ram_rd_data) < $past(byte2, 3));
  endproperty
  a_ind: assert property (p_ind) else $error("indirect compare wrong");

  property p_clear;
    take && opcode == cbx_pkg::OP_CLEAR_ACC |=> done && acc_we &&
      acc_out == 8'h00 && !carry_we && pc_out == $past(pc_in) + 16'h0001;
  endproperty
  a_clear: assert property (p_clear) else $error("clear wrong");

  property p_unsigned;
    q.st == cbx_pkg::CBX_OPER |=>
      carry_out == ({1'h0, $past(oper_dest)} < {1'h0, $past(oper_src)});
  endproperty
  a_unsigned: assert property (p_unsigned) else $error("signed compare");

  property p_target;
    q.st == cbx_pkg::CBX_OPER && oper_dest != oper_src |=>
      pc_out == $past(q.pc_base) + {{8{$past(q.rel[7])}}, $past(q.rel)};
  endproperty
  a_target: assert property (p_target) else $error("branch target");

  c_dir_branch: cover property (take && opcode == cbx_pkg::OP_CMP_A_DIR
    ##2 done && pc_out != $past(pc_in, 2) + 16'h0003);
  c_ind: cover property (take && opcode[7:1] == 7'h5b ##3 done);
  c_clear: cover property (take && opcode == cbx_pkg::OP_CLEAR_ACC);
  c_equal: cover property (q.st == cbx_pkg::CBX_OPER &&
    oper_dest == oper_src);

endmodule : cbx_exec

`default_nettype wire

// File: dv/cbx_exec_tb.sv
// Self-checking bench for the compare-branch and clear-accumulator unit
// Drives the unit directly; internal RAM is a combinational array here
`timescale 1ns/1ns
`default_nettype none

module testbench;
  logic        sys_clk = 1'h0;
  logic        rst = 1'h1;
  logic        start = 1'h0;
  logic [7:0]  opcode = 8'h00;
  logic [7:0]  byte2 = 8'h00;
  logic [7:0]  byte3 = 8'h00;
  logic [15:0] pc_in = 16'h0000;
  logic [7:0]  acc_in = 8'h00;
  logic [1:0]  bank_sel = 2'h0;
  logic        busy, ram_rd_en, done, pc_we, acc_we, carry_out, carry_we;
  logic [7:0]  ram_rd_addr, ram_rd_data, acc_out;
  logic [15:0] pc_out;
  logic [7:0]  mem [256];
  int          fails = 0;
  int          n_checks = 0;
  int          cyc = 0;

  assign ram_rd_data = mem[ram_rd_addr];
  always #10 sys_clk = ~sys_clk;

  cbx_exec cbx_exec_inst (
    .sys_clk, .rst, .start, .opcode, .byte2, .byte3, .pc_in, .acc_in,
    .bank_sel, .busy, .ram_rd_en, .ram_rd_addr, .ram_rd_data, .done,
    .pc_out, .pc_we, .acc_out, .acc_we, .carry_out, .carry_we
  );

  task automatic end_sim();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk

  // One instruction: d and s are the compared operands, lat the latency
  task automatic exec(input logic [7:0] op, b2, b3, input logic [15:0] pc,
                      input logic [7:0] acc, input logic [1:0] bk,
                      input logic [7:0] d, s, input int lat);
    int          n;
    logic        cmp;
    logic        rd;
    logic [15:0] epc;
    cmp = (lat != 1);
    rd = cmp && (op != 8'hb4);
    epc = pc + (cmp ? 16'h0003 : 16'h0001);
    if (cmp && d != s) epc = epc + {{8{b3[7]}}, b3};
    @(negedge sys_clk);
    opcode = op;
    byte2 = b2;
    byte3 = b3;
    pc_in = pc;
    acc_in = acc;
    bank_sel = bk;
    start = 1'h1;
    @(negedge sys_clk);
    start = 1'h0;
    n = 1;
    if (cmp) begin
      chk(16'(busy), 16'h0001);
      chk(16'(ram_rd_en), 16'(rd));
    end
    while (done !== 1'h1 && n < 8) begin
      @(negedge sys_clk);
      n++;
    end
    chk(16'(n), 16'(lat));
    chk(16'(busy), 16'h0000);
    chk(16'(ram_rd_en), 16'h0000);
    chk(pc_out, epc);
    chk(16'(pc_we), 16'h0001);
    chk(16'(carry_we), 16'(cmp));
    chk(16'(acc_we), 16'(!cmp));
    if (cmp) chk(16'(carry_out), 16'(d < s));
    else chk(16'(acc_out), 16'h0000);
  endtask : exec

  task automatic t_dir();
    mem[8'h30] = 8'h7f;
    exec(8'hb5, 8'h30, 8'hf0, 16'h0100, 8'h80, 2'h0, 8'h80, 8'h7f, 2);
    exec(8'hb5, 8'h30, 8'hf0, 16'h0100, 8'h7f, 2'h0, 8'h7f, 8'h7f, 2);
    mem[8'h31] = 8'hfe;
    exec(8'hb5, 8'h31, 8'h80, 16'h0180, 8'h01, 2'h0, 8'h01, 8'hfe, 2);
  endtask : t_dir

  task automatic t_imm();
    exec(8'hb4, 8'h90, 8'h05, 16'h0200, 8'h10, 2'h0, 8'h10, 8'h90, 2);
    exec(8'hb4, 8'h01, 8'h05, 16'h0200, 8'hff, 2'h0, 8'hff, 8'h01, 2);
    exec(8'hb4, 8'h55, 8'h05, 16'h0200, 8'h55, 2'h0, 8'h55, 8'h55, 2);
  endtask : t_imm

  task automatic t_reg();
    for (int r = 0; r < 8; r++) begin
      mem[{3'h0, 2'h2, 3'(r)}] = 8'h20 + 8'(r);
      exec(8'hb8 | 8'(r), 8'h24, 8'h10, 16'h0300, 8'h00, 2'h2,
           8'h20 + 8'(r), 8'h24, 2);
    end
  endtask : t_reg

  task automatic t_ind();
    for (int i = 0; i < 2; i++) begin
      mem[{3'h0, 2'h1, 2'h0, 1'(i)}] = 8'h60 + 8'(i);
      mem[8'h60 + 8'(i)] = 8'hc0;
      exec(8'hb6 | 8'(i), 8'h40, 8'h7f, 16'h0400, 8'h00, 2'h1,
           8'hc0, 8'h40, 3);
    end
  endtask : t_ind

  task automatic t_clr();
    exec(8'he4, 8'h00, 8'h00, 16'hfffe, 8'h5c, 2'h3, 8'h00, 8'h00, 1);
  endtask : t_clr

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fails++;
      end_sim();
    end
  end

  initial begin
    foreach (mem[i]) mem[i] = 8'(i) ^ 8'h5a;
    repeat (16) @(negedge sys_clk);
    rst = 1'h0;
    t_dir();
    t_imm();
    t_reg();
    t_ind();
    t_clr();
    end_sim();
  end
endmodule : testbench

`default_nettype wire
